// ### hdl/cprcs_core.v
// pointer registers, addressing modes and call stack of the cpu core
`timescale 1ns/1ns
`include "cprcs_defs.vh"
module cprcs_core #(
  parameter PC_W  = 11,
  parameter ROM_W = 16
) (
  ref_clk,
  rst_n,
  acc_in,
  imm_req,
  imm_to_acc,
  imm_addr,
  imm_data,
  imm_reject,
  dir_req,
  dir_to_ram,
  dir_addr,
  ind_req,
  ind_to_ram,
  ram_req,
  ram_we,
  ram_addr,
  ram_wdata,
  ram_rvalid,
  ram_rdata,
  tbl_req,
  rom_addr,
  rom_valid,
  rom_data,
  acc_load,
  acc_data,
  call_push,
  push_pc,
  ret_pop,
  reti_pop,
  pc_load,
  pc_data,
  pc_from_irq,
  stack_over,
  stack_pointer,
  global_irq_enable
);
  input  wire             ref_clk;
  input  wire             rst_n;
  input  wire [7:0]       acc_in;
  input  wire             imm_req;
  input  wire             imm_to_acc;
  input  wire [7:0]       imm_addr;
  input  wire [7:0]       imm_data;
  output reg              imm_reject;
  input  wire             dir_req;
  input  wire             dir_to_ram;
  input  wire [7:0]       dir_addr;
  input  wire             ind_req;
  input  wire             ind_to_ram;
  output reg              ram_req;
  output reg              ram_we;
  output reg  [15:0]      ram_addr;
  output reg  [7:0]       ram_wdata;
  input  wire             ram_rvalid;
  input  wire [7:0]       ram_rdata;
  input  wire             tbl_req;
  output wire [15:0]      rom_addr;
  input  wire             rom_valid;
  input  wire [ROM_W-1:0] rom_data;
  output reg              acc_load;
  output reg  [7:0]       acc_data;
  input  wire             call_push;
  input  wire [PC_W-1:0]  push_pc;
  input  wire             ret_pop;
  input  wire             reti_pop;
  output wire             pc_load;
  output wire [PC_W-1:0]  pc_data;
  output reg              pc_from_irq;
  output wire             stack_over;
  output wire [2:0]       stack_pointer;
  output wire             global_irq_enable;

  reg  [7:0]      tbl_high_reg;
  reg  [7:0]      offset_ptr_reg;
  reg  [7:0]      bank_ptr_reg;
  reg             gie_reg;
  reg             tbl_wait_reg;
  reg             rd_wait_reg;
  wire [15:0]     sel_addr;
  wire [PC_W-1:0] ent_rd_data;
  wire [7:0]      wr_addr;
  wire [7:0]      wr_data;
  wire            wr_go;
  wire            wr_int;
  wire            imm_ok;
  wire            dir_rd;
  wire            dir_rd_int;
  wire            sp_wr;
  wire            ent_wr;
  reg  [7:0]      int_rd_data;
  wire            rd_issue;
  wire            rd_done;
  wire            tbl_done;
  wire            pop_go;

  // registers held inside this block
  function is_internal;
    input [7:0] a;
    begin
      is_internal = (a == `CPRCS_ADDR_TBL_HIGH) || (a == `CPRCS_ADDR_OFFSET_PTR) ||
                    (a == `CPRCS_ADDR_BANK_PTR) || (a == `CPRCS_ADDR_STACK_PTR) ||
                    (a[7:4] == `CPRCS_STACK_PAGE);
    end
  endfunction

  // entry n lives at base + 2*(7-n): low byte even, high byte odd
  function [2:0] entry_index;
    input [7:0] a;
    begin
      entry_index = ~a[3:1];
    end
  endfunction

  assign imm_ok   = (imm_addr >= `CPRCS_WORK_LO) && (imm_addr <= `CPRCS_WORK_HI);
  assign dir_rd   = dir_req && !dir_to_ram;
  assign dir_rd_int = dir_rd && is_internal(dir_addr);
  assign wr_go    = (imm_req && !imm_to_acc && imm_ok) || (dir_req && dir_to_ram);
  assign wr_addr  = (imm_req && !imm_to_acc) ? imm_addr : dir_addr;
  assign wr_data  = (imm_req && !imm_to_acc) ? imm_data : acc_in;
  assign wr_int   = wr_go && is_internal(wr_addr);
  assign sp_wr    = wr_int && (wr_addr == `CPRCS_ADDR_STACK_PTR);
  assign ent_wr   = wr_int && (wr_addr[7:4] == `CPRCS_STACK_PAGE);
  assign rom_addr = {bank_ptr_reg, offset_ptr_reg};
  assign global_irq_enable = gie_reg;
  // push wins over a pop, so a lost pop must not change the return kind
  assign rd_issue = !dir_rd_int && (dir_rd || ind_req) && !rd_wait_reg;
  assign rd_done  = rd_wait_reg && ram_rvalid;
  assign tbl_done = tbl_wait_reg && rom_valid;
  assign pop_go   = (ret_pop || reti_pop) && !call_push;

  cprcs_addr_sel u_addr_sel (
    .use_pair   (ind_req),
    .bank_ptr   (bank_ptr_reg),
    .offset_ptr (offset_ptr_reg),
    .dir_addr   (dir_addr),
    .ram_addr   (sel_addr)
  );

  cprcs_stack #(
    .PC_W (PC_W)
  ) u_stack (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .push          (call_push),
    .push_pc       (push_pc),
    .pop           (ret_pop || reti_pop),
    .sp_wr         (sp_wr),
    .sp_wr_data    (wr_data[2:0]),
    .ent_wr        (ent_wr),
    .ent_wr_hi     (wr_addr[0]),
    .ent_idx       (entry_index(ent_wr ? wr_addr : dir_addr)),
    .ent_wr_data   (wr_data),
    .ent_rd_data   (ent_rd_data),
    .stack_pointer (stack_pointer),
    .pop_pc        (pc_data),
    .pop_valid     (pc_load),
    .stack_over    (stack_over)
  );

  // readback of the bank-0 system registers
  always @* begin
    int_rd_data = 8'h00;
    case (dir_addr)
      `CPRCS_ADDR_TBL_HIGH:   int_rd_data = tbl_high_reg;
      `CPRCS_ADDR_OFFSET_PTR: int_rd_data = offset_ptr_reg;
      `CPRCS_ADDR_BANK_PTR:   int_rd_data = bank_ptr_reg;
      `CPRCS_ADDR_STACK_PTR:  int_rd_data = {gie_reg, 4'h0, stack_pointer};
      default: begin
        if (dir_addr[0]) begin
          int_rd_data = {{(16 - PC_W){1'b0}}, ent_rd_data[PC_W-1:8]};
        end else begin
          int_rd_data = ent_rd_data[7:0];
        end
      end
    endcase
  end

  // pointer and table registers; a table answer beats a software write
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_high_reg   <= `CPRCS_PTR_RST;
      offset_ptr_reg <= `CPRCS_PTR_RST;
      bank_ptr_reg   <= `CPRCS_PTR_RST;
    end else begin
      if (wr_int) begin
        case (wr_addr)
          `CPRCS_ADDR_TBL_HIGH:   tbl_high_reg   <= wr_data;
          `CPRCS_ADDR_OFFSET_PTR: offset_ptr_reg <= wr_data;
          `CPRCS_ADDR_BANK_PTR:   bank_ptr_reg   <= wr_data;
          default:                tbl_high_reg   <= tbl_high_reg;
        endcase
      end
      if (tbl_done) begin
        tbl_high_reg <= rom_data[ROM_W-1:8];
      end
    end
  end

  // enable bit is written even when a push or pop drops the pointer write
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_reg <= `CPRCS_GIE_RST;
    end else if (sp_wr) begin
      gie_reg <= wr_data[`CPRCS_GIE_BIT];
    end
  end

  // answer waits; a new ram read is ignored while one is outstanding
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_wait_reg <= 1'b0;
      rd_wait_reg  <= 1'b0;
      imm_reject   <= 1'b0;
      pc_from_irq  <= 1'b0;
    end else begin
      imm_reject <= imm_req && !imm_to_acc && !imm_ok;
      if (pop_go) begin
        pc_from_irq <= reti_pop;
      end
      if (rd_issue) begin
        rd_wait_reg <= !(ind_req && ind_to_ram);
      end else if (rd_done) begin
        rd_wait_reg <= 1'b0;
      end
      // rom_addr holds the pointer pair while the program memory answers
      if (tbl_req) begin
        tbl_wait_reg <= 1'b1;
      end else if (tbl_done) begin
        tbl_wait_reg <= 1'b0;
      end
    end
  end

  // data memory port; a read request outranks a direct write
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_req   <= 1'b0;
      ram_we    <= 1'b0;
      ram_addr  <= 16'h0000;
      ram_wdata <= 8'h00;
    end else begin
      ram_req <= 1'b0;
      ram_we  <= 1'b0;
      if (rd_issue) begin
        ram_req   <= 1'b1;
        ram_we    <= ind_req && ind_to_ram;
        ram_addr  <= sel_addr;
        ram_wdata <= acc_in;
      end else if (wr_go && !wr_int) begin
        ram_req   <= 1'b1;
        ram_we    <= 1'b1;
        ram_addr  <= {`CPRCS_BANK0, wr_addr};
        ram_wdata <= wr_data;
      end
    end
  end

  // accumulator loads; one source per cycle is expected
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_load <= 1'b0;
      acc_data <= 8'h00;
    end else begin
      acc_load <= 1'b0;
      if (tbl_done) begin
        acc_load <= 1'b1;
        acc_data <= rom_data[7:0];
      end else if (rd_done) begin
        acc_load <= 1'b1;
        acc_data <= ram_rdata;
      end else if (dir_rd_int) begin
        acc_load <= 1'b1;
        acc_data <= int_rd_data;
      end else if (imm_req && imm_to_acc) begin
        acc_load <= 1'b1;
        acc_data <= imm_data;
      end
    end
  end
endmodule

// ### hdl/cprcs_defs.vh
// constants for the pointer register and call stack block
`ifndef CPRCS_DEFS_VH
`define CPRCS_DEFS_VH
`define CPRCS_ADDR_TBL_HIGH   8'h82
`define CPRCS_ADDR_OFFSET_PTR 8'h83
`define CPRCS_ADDR_BANK_PTR   8'h84
`define CPRCS_ADDR_STACK_PTR  8'hdf
`define CPRCS_ADDR_STACK_BASE 8'hf0
`define CPRCS_STACK_PAGE      4'hf
`define CPRCS_WORK_LO         8'h80
`define CPRCS_WORK_HI         8'h87
`define CPRCS_PTR_RST         8'h00
`define CPRCS_GIE_BIT         7
`define CPRCS_GIE_RST         1'b0
`define CPRCS_SP_RST          3'h7
`define CPRCS_SP_EMPTY        3'h7
`define CPRCS_ENT_RST         11'h000
`define CPRCS_DEPTH_MAX       4'h8
`define CPRCS_BANK0           8'h00
`endif

// ### hdl/cprcs_addr_sel.v
// ram address selection for direct and indirect-pair accesses
`timescale 1ns/1ns
module cprcs_addr_sel (
  use_pair,
  bank_ptr,
  offset_ptr,
  dir_addr,
  ram_addr
);
  input  wire        use_pair;
  input  wire [7:0]  bank_ptr;
  input  wire [7:0]  offset_ptr;
  input  wire [7:0]  dir_addr;
  output wire [15:0] ram_addr;

  // direct moves always land in bank 0
  assign ram_addr = use_pair ? {bank_ptr, offset_ptr} : {`CPRCS_BANK0, dir_addr};
endmodule

// ### hdl/cprcs_stack.v
// eight-level return-address stack with its pointer
`timescale 1ns/1ns
`include "cprcs_defs.vh"
module cprcs_stack #(
  parameter PC_W = 11
) (
  ref_clk,
  rst_n,
  push,
  push_pc,
  pop,
  sp_wr,
  sp_wr_data,
  ent_wr,
  ent_wr_hi,
  ent_idx,
  ent_wr_data,
  ent_rd_data,
  stack_pointer,
  pop_pc,
  pop_valid,
  stack_over
);
  input  wire            ref_clk;
  input  wire            rst_n;
  input  wire            push;
  input  wire [PC_W-1:0] push_pc;
  input  wire            pop;
  input  wire            sp_wr;
  input  wire [2:0]      sp_wr_data;
  input  wire            ent_wr;
  input  wire            ent_wr_hi;
  input  wire [2:0]      ent_idx;
  input  wire [7:0]      ent_wr_data;
  output wire [PC_W-1:0] ent_rd_data;
  output wire [2:0]      stack_pointer;
  output reg  [PC_W-1:0] pop_pc;
  output reg             pop_valid;
  output reg             stack_over;

  reg [PC_W-1:0] entry_reg [0:7];
  reg [2:0]      sp_reg;
  reg [3:0]      depth_reg;
  wire [2:0]     sp_up;
  wire [2:0]     push_idx;
  wire [2:0]     pop_idx;
  wire           full;
  integer        i;

  assign sp_up         = sp_reg + 3'h1;
  assign push_idx      = ~sp_reg;
  assign pop_idx       = ~sp_up;
  assign full          = (depth_reg == `CPRCS_DEPTH_MAX);
  assign ent_rd_data   = entry_reg[ent_idx];
  assign stack_pointer = sp_reg;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_reg     <= `CPRCS_SP_RST;
      depth_reg  <= 4'h0;
      pop_pc     <= `CPRCS_ENT_RST;
      pop_valid  <= 1'b0;
      stack_over <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        entry_reg[i] <= `CPRCS_ENT_RST;
      end
    end else begin
      pop_valid  <= 1'b0;
      stack_over <= 1'b0;
      if (push) begin
        sp_reg <= sp_reg - 3'h1;
        if (full) begin
          stack_over <= 1'b1;
        end else begin
          entry_reg[push_idx] <= push_pc;
          depth_reg           <= depth_reg + 4'h1;
        end
      end else if (pop) begin
        sp_reg    <= sp_up;
        pop_pc    <= entry_reg[pop_idx];
        pop_valid <= 1'b1;
        if (depth_reg != 4'h0) begin
          depth_reg <= depth_reg - 4'h1;
        end
      end else begin
        if (sp_wr) begin
          sp_reg    <= sp_wr_data;
          // a full stack cannot be told from an empty one by pointer alone
          depth_reg <= {1'b0, ~sp_wr_data};
        end
        if (ent_wr && ent_wr_hi) begin
          entry_reg[ent_idx][PC_W-1:8] <= ent_wr_data[PC_W-9:0];
        end else if (ent_wr) begin
          entry_reg[ent_idx][7:0] <= ent_wr_data;
        end
      end
    end
  end
endmodule

// ### verif/cprcs_exec_model.sv
// behavioural model of the core execution side: data ram and program rom
`timescale 1ns/1ns
module cprcs_exec_model (
  input  logic        ref_clk, rst_n, ram_req, ram_we, tbl_req,
  input  logic [15:0] ram_addr, rom_addr,
  input  logic [7:0]  ram_wdata,
  output logic        ram_rvalid, rom_valid,
  output logic [7:0]  ram_rdata,
  output logic [15:0] rom_data
);
  logic [7:0]  mem [0:65535];
  logic [15:0] rd_a, rom_a;
  logic [1:0]  rd_cnt, rom_cnt;
  logic        slow;
  // idle data lines toggle so a stale value never passes for an answer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ram_rvalid, rom_valid, rd_cnt, rom_cnt, slow} <= '0;
      ram_rdata <= 8'h00;
      rom_data <= 16'h0000;
    end else begin
      ram_rvalid <= rd_cnt == 2'h1;
      ram_rdata <= rd_cnt == 2'h1 ? mem[rd_a] : ~ram_rdata;
      rom_valid <= rom_cnt == 2'h1;
      rom_data <= rom_cnt == 2'h1 ? {rom_a[7:0] ^ 8'h5a, ~rom_a[15:8]} : ~rom_data;
      if (rd_cnt != 2'h0) rd_cnt <= rd_cnt - 2'h1;
      if (rom_cnt != 2'h0) rom_cnt <= rom_cnt - 2'h1;
      if (ram_req && ram_we) mem[ram_addr] <= ram_wdata;
      // alternate prompt and slow read answers
      if (ram_req && !ram_we) begin
        rd_a <= ram_addr;
        rd_cnt <= slow ? 2'h3 : 2'h1;
        slow <= ~slow;
      end
      if (tbl_req) begin
        rom_a <= rom_addr;
        rom_cnt <= 2'h2;
      end
    end
  end
endmodule

// ### verif/cprcs_checker.sv
// concurrent assertions on the pointer register and call stack ports
`timescale 1ns/1ns
module cprcs_chk (
  input logic        ref_clk, rst_n, imm_req, imm_to_acc, imm_reject, ind_req,
  input logic        ram_req, ram_rvalid, rom_valid, acc_load, call_push, ret_pop,
  input logic        reti_pop, pc_load, pc_from_irq, stack_over,
  input logic [7:0]  imm_addr, ram_rdata, acc_data,
  input logic [15:0] ram_addr, rom_addr, rom_data,
  input logic [2:0]  stack_pointer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_push;
    call_push;
  endsequence
  // push wins over a pop in the same cycle
  sequence s_pop;
    (ret_pop || reti_pop) && !call_push;
  endsequence
  a_push_step: assert property (s_push |=> stack_pointer == $past(stack_pointer) - 3'h1)
    else $error("pointer not stepped down by push");
  a_pop_step: assert property (s_pop |=> stack_pointer == $past(stack_pointer) + 3'h1)
    else $error("pointer not stepped up by pop");
  a_pop_load: assert property (s_pop |=> pc_load)
    else $error("pop gave no counter load");
  a_pop_source: assert property (s_pop |=> pc_from_irq == $past(reti_pop))
    else $error("return kind flag wrong");
  a_imm_range: assert property (imm_req && !imm_to_acc |=>
    imm_reject == ($past(imm_addr) < 8'h80 || $past(imm_addr) > 8'h87))
    else $error("immediate target check wrong");
  a_reject_cause: assert property (imm_reject |-> $past(imm_req && !imm_to_acc))
    else $error("reject without immediate move");
  a_ind_addr: assert property (ind_req |=> ram_req && ram_addr == $past(rom_addr))
    else $error("indirect address not bank and offset");
  a_ram_acc: assert property (ram_rvalid |=> acc_load && acc_data == $past(ram_rdata))
    else $error("ram read not passed to accumulator");
  a_tbl_acc: assert property (rom_valid |=> acc_load && acc_data == $past(rom_data[7:0]))
    else $error("table low byte not passed to accumulator");
  a_over_cause: assert property (stack_over |-> $past(call_push))
    else $error("stack over without push");
endmodule

// ### verif/cprcs_core_bench.sv
// self-checking bench for the pointer register and call stack block
`timescale 1ns/1ns
module cprcs_core_bench;
  logic        ref_clk = 0, rst_n = 0, imm_req = 0, imm_to_acc = 0, dir_req = 0;
  logic        dir_to_ram = 0, ind_req = 0, ind_to_ram = 0, tbl_req = 0, call_push = 0;
  logic        ret_pop = 0, reti_pop = 0;
  logic [7:0]  acc_in = 0, imm_addr = 0, imm_data = 0, dir_addr = 0;
  logic [10:0] push_pc = 0;
  wire         imm_reject, ram_req, ram_we, ram_rvalid, rom_valid, acc_load, pc_load;
  wire         pc_from_irq, stack_over, global_irq_enable;
  wire  [15:0] ram_addr, rom_addr, rom_data;
  wire  [7:0]  ram_wdata, ram_rdata, acc_data;
  wire  [10:0] pc_data;
  wire  [2:0]  stack_pointer;
  int          n_fail = 0, total_checks = 0, k;
  cprcs_core uut (.*);
  cprcs_exec_model u_model (.*);
  always #5 ref_clk = ~ref_clk;
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task wt_acc;
    #1;
    for (k = 0; k < 20 && acc_load !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("acc_load", 1, k < 20);
    if (k == 20) summarize;
  endtask
  task dacc(input logic w, input logic [7:0] a, v);
    @(posedge ref_clk) {dir_req, dir_to_ram, dir_addr, acc_in} <= {1'b1, w, a, v};
    @(posedge ref_clk) dir_req <= 0;
    if (!w) wt_acc;
    #1;
  endtask
  task imm(input logic t, input logic [7:0] a, v);
    @(posedge ref_clk) {imm_req, imm_to_acc, imm_addr, imm_data} <= {1'b1, t, a, v};
    @(posedge ref_clk) imm_req <= 0;
    #1;
  endtask
  task ind(input logic w, input logic [7:0] v);
    @(posedge ref_clk) {ind_req, ind_to_ram, acc_in} <= {1'b1, w, v};
    @(posedge ref_clk) ind_req <= 0;
    if (!w) wt_acc;
  endtask
  task push(input logic [10:0] p);
    @(posedge ref_clk) {call_push, push_pc} <= {1'b1, p};
    @(posedge ref_clk) call_push <= 0;
    #1;
  endtask
  task pop(input logic irq);
    @(posedge ref_clk) {ret_pop, reti_pop} <= {!irq, irq};
    @(posedge ref_clk) {ret_pop, reti_pop} <= 2'b00;
    #1;
  endtask
  task t_reset;
    chk("stack_pointer", 3'h7, stack_pointer);
    chk("irq_enable", 0, global_irq_enable);
    dacc(0, 8'hdf, 0);
    chk("stack_pointer_ctl", 8'h07, acc_data);
    dacc(0, 8'hf5, 0);
    chk("stack_entry", 0, acc_data);
    $display("reset test done");
  endtask
  task t_regs;
    dacc(1, 8'h84, 8'h03);
    dacc(1, 8'h83, 8'h25);
    chk("rom_addr", 16'h0325, rom_addr);
    imm(0, 8'h82, 8'ha7);
    dacc(0, 8'h82, 0);
    chk("table_high_byte", 8'ha7, acc_data);
    imm(0, 8'h90, 8'h11);
    chk("imm_reject", 1, imm_reject);
    imm(0, 8'h85, 8'h6b);
    dacc(0, 8'h85, 0);
    chk("working reg", 8'h6b, acc_data);
    imm(1, 8'h00, 8'h5c);
    chk("acc_load imm", 1, acc_load);
    @(posedge ref_clk);
    chk("acc imm", 8'h5c, acc_data);
    $display("register test done");
  endtask
  task t_mem;
    dacc(1, 8'h84, 8'h02);
    dacc(1, 8'h83, 8'h40);
    ind(1, 8'h9e);
    dacc(1, 8'h40, 8'h33);
    ind(0, 0);
    chk("indirect read", 8'h9e, acc_data);
    dacc(0, 8'h40, 0);
    chk("direct read", 8'h33, acc_data);
    // table word is derived from pointers 02/40 by the model
    @(posedge ref_clk) tbl_req <= 1;
    @(posedge ref_clk) tbl_req <= 0;
    wt_acc;
    chk("table low", 8'hfd, acc_data);
    dacc(0, 8'h82, 0);
    chk("table high", 8'h1a, acc_data);
    $display("memory test done");
  endtask
  task t_stack;
    dacc(1, 8'hdf, 8'h07);
    for (int i = 0; i < 8; i++) begin
      push(11'h5a1 + 11'(i));
      chk("sp push", 16'((6 - i) & 7), stack_pointer);
    end
    dacc(0, 8'hff, 0);
    chk("entry0 high", 8'h05, acc_data);
    dacc(0, 8'hfe, 0);
    chk("entry0 low", 8'ha1, acc_data);
    for (int i = 7; i >= 0; i--) begin
      pop(i[0]);
      chk("pc_data", 16'(11'h5a1 + i), pc_data);
      chk("pc_from_irq", 16'(i[0]), pc_from_irq);
    end
    // the ninth value differs so a store on overflow would show in entry 0
    for (int i = 0; i < 9; i++) push(i < 8 ? 11'h100 : 11'h2bb);
    chk("stack_over", 1, stack_over);
    dacc(0, 8'hfe, 0);
    chk("entry0 after over", 8'h00, acc_data);
    dacc(1, 8'hfd, 8'h02);
    dacc(0, 8'hfd, 0);
    chk("entry1 high write", 8'h02, acc_data);
    dacc(1, 8'hdf, 8'h87);
    chk("irq_enable", 1, global_irq_enable);
    push(11'h0aa);
    chk("sp after write", 3'h6, stack_pointer);
    pop(0);
    chk("pc_data", 11'h0aa, pc_data);
    $display("stack test done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1;
    #1;
    t_reset;
    t_regs;
    t_mem;
    t_stack;
    summarize;
  end
endmodule
bind cprcs_core cprcs_chk u_chk (.*);
